//--- src/sdpr_params.svh
// Purpose: Constants for one port of the synchronous dual-port RAM.
// Assumes: 128K locations of 9 bits, one rising-edge port clock.
// Notes:   Definitions only; included by the package and the modules.
`ifndef SDPR_PARAMS_SVH
`define SDPR_PARAMS_SVH

// Array geometry
`define SDPR_ADDR_W 17
`define SDPR_DATA_W 9
`define SDPR_DEPTH 131072

// Address counter values
`define SDPR_ADDR_RST 17'h00000
`define SDPR_ADDR_ONE 17'h00001

// Reset values of the output path
`define SDPR_DATA_RST 9'h000

`endif

//--- src/sdpr_pkg.sv
// Purpose: Types shared by the port logic and its memory array.
// Assumes: sdpr_params.svh supplies the widths.
// Notes:   The operation code is Gray along idle, read, write, standby.
`include "sdpr_params.svh"

package sdpr_pkg;

    // Internal address and data word
    typedef logic [`SDPR_ADDR_W-1:0] sdpr_addr_t;
    typedef logic [`SDPR_DATA_W-1:0] sdpr_data_t;

    // Operation taken at a clock edge
    typedef enum logic [1:0]
    {
        SDPR_OP_IDLE = 2'h0,
        SDPR_OP_READ = 2'h1,
        SDPR_OP_WRITE = 2'h3,
        SDPR_OP_STANDBY = 2'h2
    } sdpr_op_e;

endpackage

//--- src/sdpr_mem.sv
// Purpose: Storage array of one port, written and read at the clock edge.
// Assumes: Write and read enables are never both high.
// Notes:   Holds no reset; contents are undefined until written.
`timescale 1ns/10ps
`include "sdpr_params.svh"

module sdpr_mem
(
    input wire logic clk,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire sdpr_pkg::sdpr_addr_t addr,
    input wire sdpr_pkg::sdpr_data_t wdata,
    output sdpr_pkg::sdpr_data_t rdata
);
    import sdpr_pkg::*;

    // The cells themselves
    sdpr_data_t cells [0:`SDPR_DEPTH-1];

    // Write port: the store completes inside the cycle, so no extra edge
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            cells[addr] <= wdata;
        end
    end

    // Read port: the word leaves on the same edge that took the address
    always_ff @(posedge clk)
    begin
        if (rd_en)
        begin
            rdata <= cells[addr];
        end
    end

endmodule

//--- src/sdpr_port.sv
// Purpose: One port of a synchronous dual-port static RAM.
// Assumes: All inputs are synchronous to clk except rst_n, the output enable
//          and the latency select, which act at once.
// Notes:   data_out is muxed after flops by the latency select, data_oe by both pins.
//          That mux is the only path to a pin without a flop of its own;
//          both selects must act with no edge, so it cannot be registered.
`timescale 1ns/10ps
`include "sdpr_params.svh"

module sdpr_port
(
    input wire logic clk,
    input wire logic rst_n,
    input wire sdpr_pkg::sdpr_addr_t address,
    input wire sdpr_pkg::sdpr_data_t data_in,
    input wire logic select_active_low_n,
    input wire logic select_active_high,
    input wire logic read_write,
    input wire logic address_load_strobe_n,
    input wire logic counter_advance_enable_n,
    input wire logic counter_clear_n,
    input wire logic output_enable_n,
    input wire logic output_latency_select,
    output sdpr_pkg::sdpr_data_t data_out,
    output logic data_oe,
    output logic standby
);
    import sdpr_pkg::*;

    // ************************************************************
    // Decode of the controls presented at this edge
    // ************************************************************

    logic selected; // Both chip selects in their active state
    sdpr_op_e op_nxt; // Operation to take at this edge
    sdpr_addr_t addr_r; // Internal address held by the counter
    sdpr_addr_t addr_nxt; // Internal address used by this edge
    sdpr_data_t flow_data; // Word read at the last read edge
    sdpr_data_t pipe_data_r; // Word delayed by the output stage
    logic flow_drive_r; // Flow-through drive, from last edge's controls
    logic pipe_drive_r; // Pipelined drive, one stage later
    logic standby_r; // Port powered down

    // Bank decode: the controller keeps other banks off with these
    assign selected = ~select_active_low_n & select_active_high;

    // Classify the access from the sampled controls
    always_comb
    begin
        if (!selected)
        begin
            op_nxt = SDPR_OP_STANDBY;
        end
        else if (read_write)
        begin
            op_nxt = SDPR_OP_READ;
        end
        else
        begin
            op_nxt = SDPR_OP_WRITE;
        end
    end

    // ************************************************************
    // Address counter
    // ************************************************************

    // Clear wins, then load, then advance; the chosen value is used by
    // the access of this very edge, so clearing or advancing costs no cycle
    always_comb
    begin
        if (!counter_clear_n)
        begin
            addr_nxt = `SDPR_ADDR_RST;
        end
        else if (!address_load_strobe_n)
        begin
            addr_nxt = address;
        end
        else if (!counter_advance_enable_n)
        begin
            addr_nxt = addr_r + `SDPR_ADDR_ONE;
        end
        else
        begin
            addr_nxt = addr_r;
        end
    end

    // Counter register; it runs whether or not the port is selected
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_r <= `SDPR_ADDR_RST;
        end
        else
        begin
            addr_r <= addr_nxt;
        end
    end

    // ************************************************************
    // Storage
    // ************************************************************

    // Write enable and data are captured at the edge and the array
    // finishes the store itself, so the clock high time does not gate it
    sdpr_mem u_mem
    (
        .clk(clk),
        .wr_en(op_nxt == SDPR_OP_WRITE),
        .rd_en(op_nxt == SDPR_OP_READ),
        .addr(addr_nxt),
        .wdata(data_in),
        .rdata(flow_data)
    );

    // ************************************************************
    // Output path
    // ************************************************************

    // Flow-through drive is decided by the controls of the previous
    // cycle; a deselect or a write floats the pins after the next edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flow_drive_r <= 1'b0;
        end
        else
        begin
            flow_drive_r <= (op_nxt == SDPR_OP_READ);
        end
    end

    // Pipelined stage: a read must be seen selected at two edges before
    // the pins drive again, while a deselect still floats them at once
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pipe_drive_r <= 1'b0;
        end
        else
        begin
            pipe_drive_r <= flow_drive_r & selected;
        end
    end

    // Extra output register that gives the pipelined latency
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pipe_data_r <= `SDPR_DATA_RST;
        end
        else
        begin
            pipe_data_r <= flow_data;
        end
    end

    // Standby follows one deselected edge; a deselected edge neither writes
    // nor reads the array, so the addressed word keeps its value
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            standby_r <= 1'b1;
        end
        else
        begin
            standby_r <= ~selected;
        end
    end

    // ************************************************************
    // Pins
    // ************************************************************

    // Both pins are flops muxed by the latency select, data_oe also gated by the output enable; a flop
    // after the mux would add a cycle that the pins must not have
    assign data_out = output_latency_select ? pipe_data_r : flow_data;
    assign data_oe = ~output_enable_n &
        (output_latency_select ? pipe_drive_r : flow_drive_r);
    assign standby = standby_r;

    // ************************************************************
    // Checks
    // ************************************************************

    // Deselected once, then a selected read and still selected
    sequence s_reselect_read;
        !selected ##1 (selected && read_write) ##1 selected;
    endsequence

    // A selected read at one edge
    sequence s_read;
        selected && read_write;
    endsequence

    // Deselected at one edge and selected at the next
    sequence s_reselect;
        !selected ##1 selected;
    endsequence

    AST_OE_ASYNC: assert property (@(posedge clk) disable iff (!rst_n)
        output_enable_n |-> !data_oe)
        else $error("output enable high but pins driven");

    AST_PREV_CTRL: assert property (@(posedge clk) disable iff (!rst_n)
        s_read |=> flow_drive_r ##0 (output_enable_n || output_latency_select
        || data_oe))
        else $error("read did not drive flow-through pins next cycle");

    AST_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        (counter_clear_n && !address_load_strobe_n) |=> addr_r == $past(address))
        else $error("external address not loaded");

    AST_SELECT_ADDR: assert property (@(posedge clk) disable iff (!rst_n)
        (counter_clear_n && !address_load_strobe_n) |-> addr_nxt == address)
        else $error("internal address not taken from pins");

    AST_ADVANCE: assert property (@(posedge clk) disable iff (!rst_n)
        (counter_clear_n && address_load_strobe_n && !counter_advance_enable_n)
        |=> addr_r == sdpr_addr_t'($past(addr_r) + `SDPR_ADDR_ONE))
        else $error("counter did not advance by one");

    AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        (counter_clear_n && address_load_strobe_n && counter_advance_enable_n)
        |=> $stable(addr_r))
        else $error("counter moved while held");

    AST_WRITE_NEW: assert property (@(posedge clk) disable iff (!rst_n)
        (selected && !read_write && counter_clear_n && address_load_strobe_n
        && !counter_advance_enable_n)
        |-> addr_nxt == sdpr_addr_t'(addr_r + `SDPR_ADDR_ONE))
        else $error("advancing write not at incremented address");

    AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
        !counter_clear_n |-> addr_nxt == `SDPR_ADDR_RST ##1 addr_r == `SDPR_ADDR_RST)
        else $error("clear did not access address zero");

    AST_STANDBY: assert property (@(posedge clk) disable iff (!rst_n)
        !selected |=> standby_r && !flow_drive_r)
        else $error("deselect did not enter standby");

    AST_REACTIVATE: assert property (@(posedge clk) disable iff (!rst_n)
        s_reselect_read |-> !pipe_drive_r ##1 pipe_drive_r)
        else $error("pipelined reactivation not two cycles");

    AST_DESELECT_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
        !selected |=> !flow_drive_r && !pipe_drive_r && !data_oe)
        else $error("pins driven after deselect");

    AST_PIPE_LATE: assert property (@(posedge clk) disable iff (!rst_n)
        s_read ##1 1'b1 |=> pipe_data_r == $past(flow_data))
        else $error("pipelined data not one cycle behind");

    AST_READ_NO_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        s_read |-> op_nxt == SDPR_OP_READ)
        else $error("selected read taken as another operation");

    // The checks below guard the stage counts, where one flop too many
    // or too few would still pass the single-edge checks above
    AST_WRITE_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
        (selected && !read_write) |=> !flow_drive_r)
        else $error("write did not float flow-through pins next cycle");

    AST_WAKE: assert property (@(posedge clk) disable iff (!rst_n)
        selected |=> !standby_r)
        else $error("selected port stayed in standby");

    AST_PIPE_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
        s_reselect |=> !pipe_drive_r)
        else $error("pipelined pins drove after one selected edge");

    AST_PIPE_DRIVE: assert property (@(posedge clk) disable iff (!rst_n)
        s_read ##1 selected |=> pipe_drive_r)
        else $error("pipelined drive missing one edge after read");

endmodule

//--- dv/sdpr_ctrl.sv
// Purpose: Controller model that drives one port of the RAM.
// Assumes: Every change lands just after a falling clock edge.
// Notes:   Released data lines show the inverse of the last word.
`timescale 1ns/10ps

module sdpr_ctrl
(
    input wire logic clk,
    output sdpr_pkg::sdpr_addr_t address,
    output sdpr_pkg::sdpr_data_t data_in,
    output logic select_active_low_n,
    output logic select_active_high,
    output logic read_write,
    output logic address_load_strobe_n,
    output logic counter_advance_enable_n,
    output logic counter_clear_n,
    output logic output_enable_n,
    output logic output_latency_select
);
    import sdpr_pkg::*;

    // Deselected and quiet at time zero
    initial
    begin
        address = 17'h00000;
        data_in = 9'h000;
        {select_active_low_n, select_active_high} = 2'b10;
        read_write = 1'b1;
        {address_load_strobe_n, counter_advance_enable_n, counter_clear_n} = 3'b111;
        {output_enable_n, output_latency_select} = 2'b00;
    end

    // One cycle: sel is {low_n, high}, ctl is {load_n, advance_n, clear_n}
    task automatic cyc(input logic [1:0] sel, input logic rw, input logic [2:0] ctl,
                       input sdpr_addr_t a, input sdpr_data_t d);
        @(negedge clk);
        // Only this bank ever sees an active select pair
        {select_active_low_n, select_active_high} = sel;
        read_write = rw;
        // Shared address and controls, as for parallel slices
        {address_load_strobe_n, counter_advance_enable_n, counter_clear_n} = ctl;
        address = a;
        // A stale word on a released bus would hide capture faults
        if (rw || sel != 2'b01)
            data_in = ~data_in;
        else
            data_in = d;
    endtask

    // Asynchronous pins, changed at once
    task automatic mode(input logic oe_n, input logic pipe);
        {output_enable_n, output_latency_select} = {oe_n, pipe};
    endtask
endmodule

//--- dv/sdpr_port_tb.sv
// Purpose: Self-checking bench for one RAM port.
// Assumes: Results are read just after the next falling edge.
// Notes:   Each scenario is a task that judges its own outputs.
`timescale 1ns/10ps

module sdpr_port_tb;
    import sdpr_pkg::*;

    // ****************************************
    // Stimulus shorthand
    // ****************************************
    localparam logic [1:0] SEL = 2'b01;
    localparam logic [2:0] LD = 3'b011;
    localparam logic [2:0] ADV = 3'b101;
    localparam logic [2:0] HOLD = 3'b111;
    localparam logic [2:0] CLR = 3'b010; // Load also low: clear must win

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    int n_errors = 0;
    int tests_run = 0;
    sdpr_addr_t address;
    sdpr_data_t data_in;
    sdpr_data_t data_out;
    logic sa_n, sa, rw, ld_n, adv_n, clr_n, oe_n, lat, data_oe, standby;

    // 20 MHz port clock
    always #25 clk = ~clk;

    sdpr_ctrl sdpr_ctrl_inst (.clk(clk), .address(address), .data_in(data_in),
        .select_active_low_n(sa_n), .select_active_high(sa), .read_write(rw),
        .address_load_strobe_n(ld_n), .counter_advance_enable_n(adv_n),
        .counter_clear_n(clr_n), .output_enable_n(oe_n), .output_latency_select(lat));

    sdpr_port sdpr_port_inst (.clk(clk), .rst_n(rst_n), .address(address),
        .data_in(data_in), .select_active_low_n(sa_n), .select_active_high(sa),
        .read_write(rw), .address_load_strobe_n(ld_n), .counter_advance_enable_n(adv_n),
        .counter_clear_n(clr_n), .output_enable_n(oe_n), .output_latency_select(lat),
        .data_out(data_out), .data_oe(data_oe), .standby(standby));

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input sdpr_data_t seen, input sdpr_data_t exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic cy(input logic [1:0] s, input logic r, input logic [2:0] c,
                      input sdpr_addr_t a, input sdpr_data_t d);
        sdpr_ctrl_inst.cyc(s, r, c, a, d);
    endtask

    // Flow-through writes and reads, then the async enable
    task automatic t_flow();
        sdpr_ctrl_inst.mode(1'b0, 1'b0);
        cy(SEL, 1'b0, LD, 17'h1ffff, 9'h1a5);
        cy(SEL, 1'b0, LD, 17'h00003, 9'h05a);
        chk("oe write", 9'(data_oe), 9'h000);
        cy(SEL, 1'b1, LD, 17'h1ffff, 9'h000);
        cy(SEL, 1'b1, LD, 17'h00003, 9'h000);
        chk("flow data", data_out, 9'h1a5);
        chk("flow oe", 9'(data_oe), 9'h001);
        cy(SEL, 1'b0, LD, 17'h00003, 9'h111);
        chk("flow data", data_out, 9'h05a);
        // No edge between: the enable alone must float the pins
        #5 sdpr_ctrl_inst.mode(1'b1, 1'b0);
        #1 chk("oe async", 9'(data_oe), 9'h000);
        sdpr_ctrl_inst.mode(1'b0, 1'b0);
    endtask

    // Pipelined reads after a deselect, then a deselect with high low
    task automatic t_pipe();
        sdpr_ctrl_inst.mode(1'b0, 1'b1);
        cy(2'b11, 1'b1, LD, 17'h00000, 9'h000);
        cy(SEL, 1'b1, LD, 17'h1ffff, 9'h000);
        cy(SEL, 1'b1, LD, 17'h00003, 9'h000);
        chk("pipe oe early", 9'(data_oe), 9'h000);
        cy(SEL, 1'b1, HOLD, 17'h00000, 9'h000);
        chk("pipe data", data_out, 9'h1a5);
        chk("pipe oe", 9'(data_oe), 9'h001);
        cy(2'b00, 1'b1, HOLD, 17'h00000, 9'h000);
        chk("pipe data", data_out, 9'h111);
        cy(SEL, 1'b1, HOLD, 17'h00000, 9'h000);
        chk("pipe oe off", 9'(data_oe), 9'h000);
        sdpr_ctrl_inst.mode(1'b0, 1'b0);
    endtask

    // Counter advance on writes, then hold and advance on reads
    task automatic t_count();
        cy(SEL, 1'b0, LD, 17'h00010, 9'h0c1);
        cy(SEL, 1'b0, ADV, 17'h1ffff, 9'h0c2);
        cy(SEL, 1'b0, ADV, 17'h1ffff, 9'h0c3);
        cy(SEL, 1'b1, LD, 17'h00011, 9'h000);
        cy(SEL, 1'b1, HOLD, 17'h00000, 9'h000);
        chk("adv write", data_out, 9'h0c2);
        cy(SEL, 1'b1, ADV, 17'h00000, 9'h000);
        chk("hold", data_out, 9'h0c2);
        cy(SEL, 1'b1, HOLD, 17'h00000, 9'h000);
        chk("advance", data_out, 9'h0c3);
        cy(SEL, 1'b1, HOLD, 17'h00010, 9'h000);
        chk("counter addr", data_out, 9'h0c3);
        cy(SEL, 1'b1, HOLD, 17'h00000, 9'h000);
        chk("counter not pins", data_out, 9'h0c3);
    endtask

    // Clear with access, idle cycle, rewrite and read at zero
    task automatic t_clear();
        cy(SEL, 1'b0, CLR, 17'h00055, 9'h1e7);
        cy(SEL, 1'b1, CLR, 17'h00055, 9'h000);
        cy(2'b11, 1'b1, HOLD, 17'h00000, 9'h000);
        chk("active", 9'(standby), 9'h000);
        chk("clear write", data_out, 9'h1e7);
        // The idle cycle neither reads nor writes the word; write it again at zero
        cy(SEL, 1'b0, CLR, 17'h00055, 9'h1e7);
        chk("standby", 9'(standby), 9'h001);
        chk("oe idle", 9'(data_oe), 9'h000);
        cy(SEL, 1'b1, CLR, 17'h00055, 9'h000);
        chk("awake", 9'(standby), 9'h000);
        cy(SEL, 1'b1, HOLD, 17'h00000, 9'h000);
        chk("clear read", data_out, 9'h1e7);
    endtask

    // Bound on the whole run
    initial
    begin
        repeat (4000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        #1 chk("reset standby", 9'(standby), 9'h001);
        @(negedge clk);
        rst_n = 1'b1;
        t_flow();
        t_pipe();
        t_count();
        t_clear();
        stop_test();
    end
endmodule
